//--- design/timer16_pkg.sv
// Constants and types shared by the 16-bit timer control files
package timer16_pkg;
   // ----------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADR_W = 12;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = ADR_W - IDX_LSB;
   // Register word indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTRL_A = 10'h080;
   localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h081;
   localparam logic [IDX_W-1:0] IDX_COUNT = 10'h084;
   localparam logic [IDX_W-1:0] IDX_CAPTURE = 10'h086;
   localparam logic [IDX_W-1:0] IDX_CMP_A = 10'h088;
   localparam logic [IDX_W-1:0] IDX_CMP_B = 10'h08A;
   localparam logic [IDX_W-1:0] IDX_STATUS = 10'h08C;
   // ----------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------
   localparam int COM_LO_BASE = 6;
   localparam int COM_W = 2;
   localparam int COM_LVL_BIT = 0;
   localparam int WGM_LO_W = 2;
   localparam int WGM_B_LO = 3;
   localparam int FILT_BIT = 7;
   localparam int EDGE_BIT = 6;
   localparam int CS_W = 3;
   localparam logic [7:0] CTRL_B_MASK = 8'hDF;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam int ST_OVF = 0;
   localparam int ST_MATCH_A = 1;
   localparam int ST_MATCH_B = 2;
   localparam int ST_CAPT = 3;
   localparam int ST_W = 4;
   // ----------------------------------------------------------
   // Waveform modes, tops and clock selects
   // ----------------------------------------------------------
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_PC8 = 4'h1;
   localparam logic [3:0] WGM_PC9 = 4'h2;
   localparam logic [3:0] WGM_PC10 = 4'h3;
   localparam logic [3:0] WGM_CTC_CMP = 4'h4;
   localparam logic [3:0] WGM_FAST8 = 4'h5;
   localparam logic [3:0] WGM_FAST9 = 4'h6;
   localparam logic [3:0] WGM_FAST10 = 4'h7;
   localparam logic [3:0] WGM_PFC_CAP = 4'h8;
   localparam logic [3:0] WGM_PFC_CMP = 4'h9;
   localparam logic [3:0] WGM_PC_CAP = 4'hA;
   localparam logic [3:0] WGM_PC_CMP = 4'hB;
   localparam logic [3:0] WGM_CTC_CAP = 4'hC;
   localparam logic [3:0] WGM_FAST_CAP = 4'hE;
   localparam logic [3:0] WGM_FAST_CMP = 4'hF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam logic [15:0] COUNT_STEP = 16'h0001;
   localparam int PRESC_W = 10;
   localparam logic [PRESC_W-1:0] PRESC_STEP = 10'h001;
   localparam logic [PRESC_W-1:0] DIV8_MASK = 10'h007;
   localparam logic [PRESC_W-1:0] DIV64_MASK = 10'h03F;
   localparam logic [PRESC_W-1:0] DIV256_MASK = 10'h0FF;
   localparam logic [PRESC_W-1:0] DIV1024_MASK = 10'h3FF;
   localparam logic [CS_W-1:0] CS_STOP = 3'h0;
   localparam logic [CS_W-1:0] CS_DIV1 = 3'h1;
   localparam logic [CS_W-1:0] CS_DIV8 = 3'h2;
   localparam logic [CS_W-1:0] CS_DIV64 = 3'h3;
   localparam logic [CS_W-1:0] CS_DIV256 = 3'h4;
   localparam logic [CS_W-1:0] CS_DIV1024 = 3'h5;
   localparam logic [CS_W-1:0] CS_EXT_FALL = 3'h6;
   localparam logic [CS_W-1:0] CS_EXT_RISE = 3'h7;
   localparam int FILTER_SAMPLES = 4;
   typedef enum logic [2:0] {
      KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PHASE, KIND_PFC, KIND_RSVD
   } wave_kind_e;
endpackage

//--- design/pin_conditioner.sv
// Pin synchroniser with optional equal-sample noise filter
`timescale 1ns/1ns
module pin_conditioner #(
   parameter int SAMPLES = timer16_pkg::FILTER_SAMPLES
) (
   // Clock and reset
   input logic clk,
   input logic reset,
   // Pin and control
   input logic pin,
   input logic filter_en,
   // Conditioned level
   output logic level
);
   import timer16_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic qual;
      logic filt;
      logic [7:0] run;
   } cond_s;

   cond_s cond_reg;
   cond_s cond_next;

   // ----------------------------------------------------------
   // Qualify, then filter
   // ----------------------------------------------------------
   always_comb begin
      cond_next = cond_reg;
      cond_next.s1 = pin;
      cond_next.s2 = cond_reg.s1;
      cond_next.s3 = cond_reg.s2;
      if (cond_reg.s2 == cond_reg.s3) begin
         cond_next.qual = cond_reg.s3;
      end
      // Count successive samples that differ from the held output
      if (cond_reg.qual != cond_reg.filt) begin
         if (cond_reg.run == 8'(SAMPLES - 1)) begin
            cond_next.filt = cond_reg.qual;
            cond_next.run = '0;
         end else begin
            cond_next.run = cond_reg.run + 8'h01;
         end
      end else begin
         cond_next.run = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cond_reg <= '0;
      end else begin
         cond_reg <= cond_next;
      end
   end

   assign level = filter_en ? cond_reg.filt : cond_reg.qual;
endmodule

//--- design/timer16_waveform_capture_ctrl.sv
// 16-bit timer control: waveform modes, compare outputs, capture
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
// Contract
// - Nonzero compare output mode routes the channel waveform to its pin, except mode 1 in modes where toggle is not allowed.
// - Pad driver enabled only when the pin direction selects output.
// - Non-PWM: mode 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM mode 1 toggles A only in modes 14/15; else off.
// - Fast PWM: 2 clears on match, sets at bottom; 3 inverse.
// - Fast PWM modes 2/3: match at TOP ignored, bottom action still done.
// - Dual-slope mode 1 toggles A only in modes 9/11; else off.
// - Dual-slope: 2 clears up, sets down on match; 3 inverse.
// - Waveform mode: two bits in control A, two in control B.
// - Mode 0 normal, TOP 0xFFFF, immediate update, overflow at MAX.
// - Modes 1-3 phase correct 8/9/10 bit, update TOP, flag BOTTOM.
// - Mode 4 clear-on-match, TOP compare A, immediate, flag MAX.
// - Mode 12 clear-on-match, TOP capture; mode 13 reserved.
// - Modes 5-7 fast PWM 8/9/10 bit, update BOTTOM, flag TOP.
// - Modes 8/9 phase-frequency correct, update and flag at BOTTOM.
// - Modes 10/11 phase correct, update TOP, flag BOTTOM.
// - Filter changes output after four successive equal samples.
// - Filter delays capture events by four clock cycles.
// - Edge select 0 captures falling edge, 1 rising edge.
// - Capture copies counter to capture register and sets flag.
// - Capture disabled while the capture register is TOP.
// - Clock select: stop, divide 1..1024, external falling/rising.
module timer16_waveform_capture_ctrl #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input logic clk,
   input logic reset,
   // Wishbone slave
   input logic wb_cyc,
   input logic wb_stb,
   input logic wb_we,
   input logic [3:0] wb_sel,
   input logic [timer16_pkg::ADR_W-1:0] wb_adr,
   input logic [timer16_pkg::DATA_W-1:0] wb_dat_w,
   output logic [timer16_pkg::DATA_W-1:0] wb_dat_r,
   output logic wb_ack,
   // Pins
   input logic capture_input_pin,
   input logic ext_clk_pin,
   // Ordinary port function of the compare pins
   input logic port_out_a,
   input logic port_out_b,
   input logic port_dir_a,
   input logic port_dir_b,
   // Compare pads
   output logic wave_out_a,
   output logic wave_out_a_oe,
   output logic wave_out_b,
   output logic wave_out_b_oe,
   // Flags
   output logic overflow_flag,
   output logic capture_flag
);
   import timer16_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [15:0] count;
      logic [15:0] capture;
      logic [CHANNELS-1:0][15:0] cmp;
      logic [CHANNELS-1:0][15:0] cmp_buf;
      logic down;
      logic [PRESC_W-1:0] presc;
      logic [CHANNELS-1:0] wave;
      logic [ST_W-1:0] flags;
      logic skip_match;
      logic ext_prev;
      logic cap_prev;
      logic ack;
      logic [DATA_W-1:0] rdata;
      logic [CHANNELS-1:0] pad;
      logic [CHANNELS-1:0] pad_oe;
   } state_s;

   state_s state_reg;
   state_s state_next;

   logic [3:0] waveform_mode_sel;
   wave_kind_e kind;
   logic [15:0] top;
   logic top_is_capture;
   logic non_pwm;
   logic a_toggle_mode;
   logic tick;
   logic at_top;
   logic at_bottom;
   logic cap_level;
   logic ext_level;
   logic [CHANNELS-1:0] conn;
   logic [CHANNELS-1:0] match;
   logic [CHANNELS-1:0] wave_nxt;
   logic [CHANNELS-1:0] port_out;
   logic [CHANNELS-1:0] port_dir;

   assign port_out = {port_out_b, port_out_a};
   assign port_dir = {port_dir_b, port_dir_a};

   // ----------------------------------------------------------
   // Pin conditioning
   // ----------------------------------------------------------
   pin_conditioner #(.SAMPLES(FILTER_SAMPLES)) u_cap_cond (
      .clk(clk),
      .reset(reset),
      .pin(capture_input_pin),
      .filter_en(state_reg.ctrl_b[FILT_BIT]),
      .level(cap_level)
   );

   pin_conditioner #(.SAMPLES(FILTER_SAMPLES)) u_ext_cond (
      .clk(clk),
      .reset(reset),
      .pin(ext_clk_pin),
      .filter_en(1'b0),
      .level(ext_level)
   );

   // ----------------------------------------------------------
   // Waveform mode decode
   // ----------------------------------------------------------
   assign waveform_mode_sel = {state_reg.ctrl_b[WGM_B_LO +: WGM_LO_W],
                               state_reg.ctrl_a[WGM_LO_W-1:0]};

   always_comb begin
      kind = KIND_RSVD;
      top = COUNT_MAX;
      top_is_capture = 1'b0;
      case (waveform_mode_sel)
         WGM_NORMAL: kind = KIND_NORMAL;
         WGM_PC8: begin
            kind = KIND_PHASE;
            top = TOP_8BIT;
         end
         WGM_PC9: begin
            kind = KIND_PHASE;
            top = TOP_9BIT;
         end
         WGM_PC10: begin
            kind = KIND_PHASE;
            top = TOP_10BIT;
         end
         WGM_CTC_CMP: begin
            kind = KIND_CTC;
            top = state_reg.cmp[0];
         end
         WGM_FAST8: begin
            kind = KIND_FAST;
            top = TOP_8BIT;
         end
         WGM_FAST9: begin
            kind = KIND_FAST;
            top = TOP_9BIT;
         end
         WGM_FAST10: begin
            kind = KIND_FAST;
            top = TOP_10BIT;
         end
         WGM_PFC_CAP: begin
            kind = KIND_PFC;
            top = state_reg.capture;
            top_is_capture = 1'b1;
         end
         WGM_PFC_CMP: begin
            kind = KIND_PFC;
            top = state_reg.cmp[0];
         end
         WGM_PC_CAP: begin
            kind = KIND_PHASE;
            top = state_reg.capture;
            top_is_capture = 1'b1;
         end
         WGM_PC_CMP: begin
            kind = KIND_PHASE;
            top = state_reg.cmp[0];
         end
         WGM_CTC_CAP: begin
            kind = KIND_CTC;
            top = state_reg.capture;
            top_is_capture = 1'b1;
         end
         WGM_FAST_CAP: begin
            kind = KIND_FAST;
            top = state_reg.capture;
            top_is_capture = 1'b1;
         end
         WGM_FAST_CMP: begin
            kind = KIND_FAST;
            top = state_reg.cmp[0];
         end
         default: kind = KIND_RSVD;
      endcase
   end

   assign non_pwm = (kind == KIND_NORMAL) || (kind == KIND_CTC) ||
                    (kind == KIND_RSVD);
   assign a_toggle_mode = (waveform_mode_sel == WGM_PFC_CMP) ||
                          (waveform_mode_sel == WGM_PC_CMP) ||
                          (waveform_mode_sel == WGM_FAST_CAP) ||
                          (waveform_mode_sel == WGM_FAST_CMP);
   assign at_top = (state_reg.count == top);
   assign at_bottom = (state_reg.count == COUNT_BOTTOM);

   // ----------------------------------------------------------
   // Clock select
   // ----------------------------------------------------------
   always_comb begin
      case (state_reg.ctrl_b[CS_W-1:0])
         CS_STOP: tick = 1'b0;
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = (state_reg.presc & DIV8_MASK) == DIV8_MASK;
         CS_DIV64: tick = (state_reg.presc & DIV64_MASK) == DIV64_MASK;
         CS_DIV256: tick = (state_reg.presc & DIV256_MASK) == DIV256_MASK;
         CS_DIV1024: tick = state_reg.presc == DIV1024_MASK;
         CS_EXT_FALL: tick = state_reg.ext_prev && !ext_level;
         CS_EXT_RISE: tick = !state_reg.ext_prev && ext_level;
         default: tick = 1'b0;
      endcase
   end

   // ----------------------------------------------------------
   // Compare output units
   // ----------------------------------------------------------
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
      logic [COM_W-1:0] com;
      logic toggle_ok;
      logic w;
      assign com = state_reg.ctrl_a[COM_LO_BASE - COM_W*ch +: COM_W];
      assign toggle_ok = non_pwm || (ch == 0 && a_toggle_mode);
      assign conn[ch] = (com != COM_OFF) &&
                        (com != COM_TOGGLE || toggle_ok);
      assign match[ch] = tick && !state_reg.skip_match &&
                         (state_reg.count == state_reg.cmp[ch]);
      always_comb begin
         // Held while disconnected
         w = state_reg.wave[ch];
         if (conn[ch] && tick && kind != KIND_RSVD) begin
            if (com == COM_TOGGLE) begin
               if (match[ch]) begin
                  w = !state_reg.wave[ch];
               end
            end else if (non_pwm) begin
               if (match[ch]) begin
                  w = com[COM_LVL_BIT];
               end
            end else if (kind == KIND_FAST) begin
               if (at_top) begin
                  w = !com[COM_LVL_BIT];
               end else if (match[ch]) begin
                  w = com[COM_LVL_BIT];
               end
            end else if (match[ch]) begin
               w = state_reg.down ^ com[COM_LVL_BIT];
            end
         end
      end
      assign wave_nxt[ch] = w;
   end

   // ----------------------------------------------------------
   // Register bus helpers
   // ----------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [DATA_W-1:0] d,
                                           input logic [3:0] sel);
      merge16 = old;
      if (sel[0]) begin
         merge16[7:0] = d[7:0];
      end
      if (sel[1]) begin
         merge16[15:8] = d[15:8];
      end
   endfunction

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always_comb begin
      logic req;
      logic wr;
      logic imm;
      logic upd;
      logic cap_edge;
      logic [IDX_W-1:0] idx;
      logic [ST_W-1:0] set;
      logic [ST_W-1:0] clr;
      req = wb_cyc && wb_stb;
      wr = req && state_reg.ack && wb_we;
      idx = wb_adr[ADR_W-1:IDX_LSB];
      imm = (kind == KIND_NORMAL) || (kind == KIND_CTC);
      upd = 1'b0;
      set = '0;
      clr = '0;
      cap_edge = 1'b0;
      state_next = state_reg;
      state_next.presc = state_reg.presc + PRESC_STEP;
      state_next.ext_prev = ext_level;
      state_next.cap_prev = cap_level;
      if (tick) begin
         state_next.skip_match = 1'b0;
      end

      // Counter sequence
      if (tick) begin
         case (kind)
            KIND_NORMAL, KIND_CTC: begin
               state_next.count = at_top ? COUNT_BOTTOM :
                                  state_reg.count + COUNT_STEP;
               set[ST_OVF] = state_reg.count == COUNT_MAX;
            end
            KIND_FAST: begin
               state_next.count = at_top ? COUNT_BOTTOM :
                                  state_reg.count + COUNT_STEP;
               set[ST_OVF] = at_top;
               upd = at_top;
            end
            KIND_PHASE, KIND_PFC: begin
               if (state_reg.down && at_bottom) begin
                  state_next.down = 1'b0;
                  state_next.count = state_reg.count + COUNT_STEP;
               end else if (!state_reg.down && at_top) begin
                  state_next.down = 1'b1;
                  state_next.count = state_reg.count - COUNT_STEP;
               end else if (state_reg.down) begin
                  state_next.count = state_reg.count - COUNT_STEP;
               end else begin
                  state_next.count = state_reg.count + COUNT_STEP;
               end
               set[ST_OVF] = at_bottom;
               upd = (kind == KIND_PHASE) ? at_top : at_bottom;
            end
            default: state_next.count = state_reg.count;
         endcase
      end
      if (upd) begin
         state_next.cmp = state_reg.cmp_buf;
      end
      set[ST_MATCH_A] = match[0];
      set[ST_MATCH_B] = match[1];
      state_next.wave = wave_nxt;

      // Input capture
      cap_edge = state_reg.ctrl_b[EDGE_BIT] ?
                 (!state_reg.cap_prev && cap_level) :
                 (state_reg.cap_prev && !cap_level);
      if (cap_edge && !top_is_capture) begin
         state_next.capture = state_reg.count;
         set[ST_CAPT] = 1'b1;
      end

      // Bus answer and read data
      state_next.ack = req && !state_reg.ack;
      if (req && !state_reg.ack) begin
         case (idx)
            IDX_CTRL_A: state_next.rdata = DATA_W'(state_reg.ctrl_a);
            IDX_CTRL_B: state_next.rdata = DATA_W'(state_reg.ctrl_b);
            IDX_COUNT: state_next.rdata = DATA_W'(state_reg.count);
            IDX_CAPTURE: state_next.rdata = DATA_W'(state_reg.capture);
            IDX_CMP_A: state_next.rdata = DATA_W'(state_reg.cmp_buf[0]);
            IDX_CMP_B: state_next.rdata = DATA_W'(state_reg.cmp_buf[1]);
            IDX_STATUS: state_next.rdata = DATA_W'(state_reg.flags);
            default: state_next.rdata = '0;
         endcase
      end

      // Register writes take effect at the acknowledged edge
      if (wr) begin
         case (idx)
            IDX_CTRL_A: begin
               if (wb_sel[0]) begin
                  state_next.ctrl_a = wb_dat_w[7:0];
               end
            end
            IDX_CTRL_B: begin
               if (wb_sel[0]) begin
                  state_next.ctrl_b = wb_dat_w[7:0] & CTRL_B_MASK;
               end
            end
            IDX_COUNT: begin
               state_next.count = merge16(state_reg.count, wb_dat_w,
                                          wb_sel);
               state_next.skip_match = |wb_sel[1:0];
            end
            IDX_CAPTURE: begin
               state_next.capture = merge16(state_reg.capture, wb_dat_w,
                                            wb_sel);
            end
            IDX_CMP_A, IDX_CMP_B: begin
               for (int c = 0; c < CHANNELS; c++) begin
                  if (idx == (c == 0 ? IDX_CMP_A : IDX_CMP_B)) begin
                     state_next.cmp_buf[c] = merge16(state_reg.cmp_buf[c],
                                                     wb_dat_w, wb_sel);
                     if (imm) begin
                        state_next.cmp[c] = state_next.cmp_buf[c];
                     end
                  end
               end
            end
            IDX_STATUS: begin
               if (wb_sel[0]) begin
                  clr = wb_dat_w[ST_W-1:0];
               end
            end
            default: state_next.rdata = state_reg.rdata;
         endcase
      end
      // A flag set in the clearing cycle survives
      state_next.flags = (state_reg.flags & ~clr) | set;

      // Compare pads
      for (int c = 0; c < CHANNELS; c++) begin
         state_next.pad[c] = conn[c] ? wave_nxt[c] : port_out[c];
         state_next.pad_oe[c] = port_dir[c];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   assign wb_dat_r = state_reg.rdata;
   assign wb_ack = state_reg.ack;
   assign wave_out_a = state_reg.pad[0];
   assign wave_out_a_oe = state_reg.pad_oe[0];
   assign wave_out_b = state_reg.pad[1];
   assign wave_out_b_oe = state_reg.pad_oe[1];
   assign overflow_flag = state_reg.flags[ST_OVF];
   assign capture_flag = state_reg.flags[ST_CAPT];
endmodule

//--- tb/timer16_waveform_capture_ctrl_props.sv
// Port assertions for the 16-bit timer control block
`timescale 1ns/1ns
module timer16_waveform_capture_ctrl_props #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Wishbone slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [3:0] wb_sel,
   input wire logic [timer16_pkg::ADR_W-1:0] wb_adr,
   input wire logic [timer16_pkg::DATA_W-1:0] wb_dat_w,
   input wire logic [timer16_pkg::DATA_W-1:0] wb_dat_r,
   input wire logic wb_ack,
   // Pins and port function
   input wire logic capture_input_pin,
   input wire logic ext_clk_pin,
   input wire logic port_out_a,
   input wire logic port_out_b,
   input wire logic port_dir_a,
   input wire logic port_dir_b,
   // Pads and flags
   input wire logic wave_out_a,
   input wire logic wave_out_a_oe,
   input wire logic wave_out_b,
   input wire logic wave_out_b_oe,
   input wire logic overflow_flag,
   input wire logic capture_flag
);
   import timer16_pkg::*;
   // ----------------------------------------
   // Control shadows, taken early so they lead
   // ----------------------------------------
   logic take, st_req, off_a, off_b, ctop, off_a_q, off_b_q, ctop_q;
   logic [7:0] sh_a, sh_b;
   assign take = wb_cyc && wb_stb && !wb_ack && wb_we && wb_sel[0];
   assign st_req = wb_cyc && wb_stb && wb_we && wb_adr == {IDX_STATUS, 2'h0};
   assign off_a = sh_a[7:6] == COM_OFF;
   assign off_b = sh_a[5:4] == COM_OFF;
   assign ctop = sh_b[4] && !sh_a[0];
   always_ff @(posedge clk) begin
      if (reset) begin
         sh_a <= CTRL_RESET;
         sh_b <= CTRL_RESET;
      end else if (take && wb_adr == {IDX_CTRL_A, 2'h0}) begin
         sh_a <= wb_dat_w[7:0];
      end else if (take && wb_adr == {IDX_CTRL_B, 2'h0}) begin
         sh_b <= wb_dat_w[7:0];
      end
      off_a_q <= off_a;
      off_b_q <= off_b;
      ctop_q <= ctop;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ack_one_cycle_a: assert property (wb_ack |=> !wb_ack)
      else $error("ack longer than one cycle");
   ack_latency_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("ack not one cycle after request");
   pass_port_a_a: assert property (
      !$past(reset) && $past(off_a) && $past(off_a_q)
      |-> wave_out_a == $past(port_out_a)) else $error("pad a not port");
   pass_port_b_a: assert property (
      !$past(reset) && $past(off_b) && $past(off_b_q)
      |-> wave_out_b == $past(port_out_b)) else $error("pad b not port");
   drive_en_a_a: assert property (
      !$past(reset) |-> wave_out_a_oe == $past(port_dir_a))
      else $error("pad a enable wrong");
   drive_en_b_a: assert property (
      !$past(reset) |-> wave_out_b_oe == $past(port_dir_b))
      else $error("pad b enable wrong");
   ovf_sticky_a: assert property (
      overflow_flag && !st_req |=> overflow_flag)
      else $error("overflow flag lost");
   capt_sticky_a: assert property (
      capture_flag && !st_req |=> capture_flag)
      else $error("capture flag lost");
   capt_blocked_a: assert property (
      $past(ctop) && $past(ctop_q) |-> !$rose(capture_flag))
      else $error("capture while capture is top");
   write_c: cover property (wb_ack && wb_we);
   capt_c: cover property ($rose(capture_flag));
   ovf_c: cover property ($rose(overflow_flag));
endmodule

//--- tb/timer16_waveform_capture_ctrl_bench.sv
// Self-checking bench for the 16-bit timer control block
`timescale 1ns/1ns
module timer16_waveform_capture_ctrl_bench;
   import timer16_pkg::*;
   logic clk, reset, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [3:0] wb_sel;
   logic [ADR_W-1:0] wb_adr;
   logic [DATA_W-1:0] wb_dat_w, wb_dat_r, q;
   logic capture_input_pin, ext_clk_pin, port_out_a, port_out_b;
   logic port_dir_a, port_dir_b, wave_out_a, wave_out_a_oe;
   logic wave_out_b, wave_out_b_oe, overflow_flag, capture_flag;
   int n_errors = 0;
   int n_checks = 0;
   int c1, c2;
   timer16_waveform_capture_ctrl i_timer16_waveform_capture_ctrl (.*);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic we, input logic [IDX_W-1:0] i,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {i, 2'h0};
      wb_dat_w <= d;
      for (k = 0; k < 20 && wb_ack !== 1'b1; k++) begin
         @(posedge clk);
      end
      if (k == 20) begin
         chk(0, 1);
         tally_and_finish();
      end
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task automatic wait_sig(input int s, input logic v, output int c);
      logic [2:0] w;
      for (c = 0; c < 300; c++) begin
         w = {wave_out_a, overflow_flag, capture_flag};
         if (w[s] === v) break;
         @(posedge clk);
      end
      if (c == 300) begin
         chk(0, 1);
         tally_and_finish();
      end
   endtask
   task automatic cap(input logic [7:0] b, input logic p, output int c);
      bus(1, IDX_CTRL_B, b);
      bus(1, IDX_STATUS, 32'hF);
      @(posedge clk);
      capture_input_pin <= p;
      wait_sig(0, 1'b1, c);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      {reset, wb_sel} = 5'h13;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
      {capture_input_pin, ext_clk_pin, port_out_a, port_out_b} = 4'h0;
      {port_dir_a, port_dir_b} = 2'h3;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      bus(0, IDX_CTRL_A, 0);
      chk(q, 0);
      bus(1, IDX_CTRL_B, 32'hFF);
      bus(0, IDX_CTRL_B, 0);
      chk(q, 32'hDF);
      bus(0, 10'h3F0, 0);
      chk(q, 0);
      bus(1, IDX_CTRL_B, 0);
      bus(1, IDX_COUNT, 32'h1234);
      cap(8'h40, 1'b1, c1);
      bus(0, IDX_CAPTURE, 0);
      chk(q, 32'h1234);
      bus(1, IDX_STATUS, 32'hF);
      @(posedge clk);
      capture_input_pin <= 1'b0;
      repeat (12) @(posedge clk);
      chk(capture_flag, 0);
      cap(8'hC0, 1'b1, c2);
      chk(c2 - c1, 4);
      cap(8'h80, 1'b0, c2);
      chk(c2 - c1, 4);
      bus(1, IDX_CTRL_B, 8'h58);
      bus(1, IDX_STATUS, 32'hF);
      @(posedge clk);
      capture_input_pin <= 1'b1;
      repeat (20) @(posedge clk);
      chk(capture_flag, 0);
      // Normal mode: overflow at MAX, toggle A on the match at zero
      bus(1, IDX_CTRL_A, 8'h40);
      bus(1, IDX_COUNT, 32'hFFF0);
      bus(1, IDX_STATUS, 32'hF);
      bus(1, IDX_CTRL_B, 32'h1);
      wait_sig(1, 1'b1, c1);
      wait_sig(2, 1'b1, c2);
      chk(c2, 1);
      chk({wave_out_a_oe, wave_out_b}, 2'h2);
      bus(1, IDX_CTRL_A, 0);
      repeat (2) @(posedge clk);
      chk(wave_out_a, port_out_a);
      bus(1, IDX_CTRL_A, 8'h40);
      repeat (2) @(posedge clk);
      chk(wave_out_a, 1);
      tally_and_finish();
   end
endmodule
bind timer16_waveform_capture_ctrl timer16_waveform_capture_ctrl_props
   #(.CHANNELS(CHANNELS)) i_timer16_waveform_capture_ctrl_props (.*);
